// ---- hdl/dip_peak_map.vh ----
// register offsets, field positions, reset values and limits of the dip and peak monitor
`ifndef DIP_PEAK_MAP_VH
`define DIP_PEAK_MAP_VH

// register indices on the register port
`define ADDR_EVENT_STATUS  4'h0
`define ADDR_EVENT_MASK    4'h1
`define ADDR_PHASE_STATUS  4'h2
`define ADDR_DIP_THRESHOLD 4'h3
`define ADDR_DIP_COUNT     4'h4
`define ADDR_MEAS_MODE     4'h5
`define ADDR_PEAK_WINDOW   4'h6
`define ADDR_VOLT_PEAK     4'h7
`define ADDR_CURR_PEAK     4'h8

// event status and mask bit positions
`define BIT_DIP_EVENT      16
`define BIT_CURR_PEAK_DONE 23
`define BIT_VOLT_PEAK_DONE 24

// field positions
`define POS_DIP_PHASE_LO   12
`define POS_PEAK_SEL_LO    2
`define POS_PEAK_FLAGS_LO  24

// threshold values at or below this level mean a level of zero
`define DIP_LEVEL_ZERO_MAX 24'h000001

// reset values
`define RST_DIP_THRESHOLD  24'h000000
`define RST_DIP_COUNT      8'h00
`define RST_PEAK_WINDOW    8'h00
`define RST_PEAK_SEL       3'h0
`define RST_MASK           3'h0

`endif

// ---- hdl/voltage_dip_and_peak_monitor.v ----
// dip detector, peak recorder and event status logic of the metering front end
// Notes on behaviour
// - dip flag bit 16 on persistent below/above
// - phase A state bit follows dip result
// - phases B and C state bits likewise
// - eight-bit half-cycle count, zero invalid
// - masked dip flag pulls interrupt low immediately
// - writing one clears dip flag, releases interrupt
// - count write after threshold set resets counter
// - compare threshold with absolute filtered voltage
// - full scale always dips, zero/one never
// - threshold read as 32 bits, top zero
// - peaks stored in low 24 bits
// - window counts half-line cycles from zero crossings
// - mode bits 4:2 select peak phases
// - each cycle with a selected phase crossing advances window by one
// - one-hot phase flag in bits 26:24
// - peaks update at window end, then hold
// - current window end sets bit 23
// - voltage window end sets bit 24
// - window write with selection resets counter
`timescale 1ns/1ps
`include "dip_peak_map.vh"

module voltage_dip_and_peak_monitor (
  // clock and reset
  input  wire        SYS_CLK,
  input  wire        RST_N,
  // register port
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [3:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  output reg  [31:0] REG_RDATA,
  // filtered samples
  input  wire        SAMPLE_VALID,
  input  wire [23:0] V_A,
  input  wire [23:0] V_B,
  input  wire [23:0] V_C,
  input  wire [23:0] I_A,
  input  wire [23:0] I_B,
  input  wire [23:0] I_C,
  // voltage zero-crossing pulses
  input  wire        ZX_A,
  input  wire        ZX_B,
  input  wire        ZX_C,
  // interrupt
  output reg         IRQ_N
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // absolute value of sample
  function [23:0] abs24;
    input [23:0] s;
    begin
      abs24 = s[23] ? (~s + 24'h000001) : s;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [23:0] dip_threshold_reg;
  reg         dip_threshold_set_reg;
  reg  [7:0]  dip_half_cycle_count_reg;
  reg  [2:0]  peak_phase_select_reg;
  reg  [7:0]  peak_window_halfcycles_reg;
  reg  [2:0]  event_mask_reg;
  reg         dip_flag_reg;
  reg         current_peak_done_flag;
  reg         voltage_peak_done_flag;
  reg  [2:0]  dip_phase_state;
  reg  [2:0]  seen_low_reg;
  reg  [2:0]  seen_high_reg;
  reg  [2:0]  last_low_reg;
  reg  [7:0]  dip_cnt_reg [0:2];
  reg  [7:0]  peak_cnt_reg;
  reg  [23:0] vmax_reg;
  reg  [2:0]  vmax_ph_reg;
  reg  [23:0] imax_reg;
  reg  [2:0]  imax_ph_reg;
  reg  [26:0] voltage_peak_value;
  reg  [26:0] current_peak_value;

  wire [2:0]  zx = {ZX_C, ZX_B, ZX_A};
  wire [23:0] v_abs [0:2];
  wire [23:0] i_abs [0:2];
  assign v_abs[0] = abs24(V_A);
  assign v_abs[1] = abs24(V_B);
  assign v_abs[2] = abs24(V_C);
  assign i_abs[0] = abs24(I_A);
  assign i_abs[1] = abs24(I_B);
  assign i_abs[2] = abs24(I_C);

  wire wr_status = REG_WR && (REG_ADDR == `ADDR_EVENT_STATUS);
  // count write resets dip counters once threshold is set
  wire dip_restart = REG_WR && (REG_ADDR == `ADDR_DIP_COUNT) && dip_threshold_set_reg;
  // window write resets window when a phase is selected
  wire peak_restart = REG_WR && (REG_ADDR == `ADDR_PEAK_WINDOW) && (|peak_phase_select_reg);

  // ----------------------------------------------------------------
  // dip comparison and half-cycle qualification
  // ----------------------------------------------------------------
  reg  [2:0] below;
  reg  [2:0] dip_fire;
  reg  [2:0] fire_low;
  reg  [7:0] cnt_next [0:2];
  reg        whole_low;
  reg        whole_high;
  integer    p;
  integer    q;
  integer    r;

  always @* begin
    whole_low  = 1'b0;
    whole_high = 1'b0;
    for (p = 0; p < 3; p = p + 1) begin
      // a level of 0 or 1 is zero, so nothing is ever below it
      below[p] = (dip_threshold_reg > `DIP_LEVEL_ZERO_MAX) && (v_abs[p] < dip_threshold_reg);
      whole_low  = seen_low_reg[p] && !seen_high_reg[p];
      whole_high = seen_high_reg[p] && !seen_low_reg[p];
      dip_fire[p]    = 1'b0;
      fire_low[p]    = whole_low;
      cnt_next[p]    = dip_cnt_reg[p];
      if (zx[p]) begin
        // below half cycles always count, above ones only while in a dip
        if (!(whole_low || (whole_high && dip_phase_state[p]))) begin
          cnt_next[p] = 8'h00;
        end else if (dip_cnt_reg[p] != 8'h00 && last_low_reg[p] != whole_low) begin
          cnt_next[p] = 8'h01;
        end else begin
          cnt_next[p] = dip_cnt_reg[p] + 8'h01;
        end
        // fire at end of the programmed half cycle; zero never fires
        if (dip_half_cycle_count_reg != 8'h00 && cnt_next[p] == dip_half_cycle_count_reg) begin
          dip_fire[p] = 1'b1;
          cnt_next[p] = 8'h00;
        end
      end
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dip_phase_state <= 3'h0;
      seen_low_reg    <= 3'h0;
      seen_high_reg   <= 3'h0;
      last_low_reg    <= 3'h0;
      for (q = 0; q < 3; q = q + 1) begin
        dip_cnt_reg[q] <= 8'h00;
      end
    end else if (dip_restart) begin
      seen_low_reg  <= 3'h0;
      seen_high_reg <= 3'h0;
      for (q = 0; q < 3; q = q + 1) begin
        dip_cnt_reg[q] <= 8'h00;
      end
    end else begin
      for (q = 0; q < 3; q = q + 1) begin
        dip_cnt_reg[q] <= cnt_next[q];
        if (zx[q]) begin
          last_low_reg[q]  <= fire_low[q];
          seen_low_reg[q]  <= SAMPLE_VALID && below[q];
          seen_high_reg[q] <= SAMPLE_VALID && !below[q];
        end else if (SAMPLE_VALID) begin
          seen_low_reg[q]  <= seen_low_reg[q] | below[q];
          seen_high_reg[q] <= seen_high_reg[q] | !below[q];
        end
        // phase state one while below, zero once above
        if (dip_fire[q]) begin
          dip_phase_state[q] <= fire_low[q];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // peak tracking over the window
  // ----------------------------------------------------------------
  reg  [23:0] vcand;
  reg  [2:0]  vcand_ph;
  reg  [23:0] icand;
  reg  [2:0]  icand_ph;

  always @* begin
    vcand    = vmax_reg;
    vcand_ph = vmax_ph_reg;
    icand    = imax_reg;
    icand_ph = imax_ph_reg;
    for (r = 0; r < 3; r = r + 1) begin
      if (SAMPLE_VALID && peak_phase_select_reg[r] && v_abs[r] > vcand) begin
        vcand    = v_abs[r];
        vcand_ph = 3'h1 << r;
      end
      if (SAMPLE_VALID && peak_phase_select_reg[r] && i_abs[r] > icand) begin
        icand    = i_abs[r];
        icand_ph = 3'h1 << r;
      end
    end
  end

  // any selected phase crossing advances the window
  wire       zx_sel     = |(zx & peak_phase_select_reg);
  wire [7:0] peak_cnt_inc = peak_cnt_reg + 8'h01;
  wire       window_end = zx_sel && (peak_cnt_inc >= peak_window_halfcycles_reg);

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      peak_cnt_reg       <= 8'h00;
      vmax_reg           <= 24'h000000;
      vmax_ph_reg        <= 3'h0;
      imax_reg           <= 24'h000000;
      imax_ph_reg        <= 3'h0;
      voltage_peak_value <= 27'h0000000;
      current_peak_value <= 27'h0000000;
    end else if (peak_restart) begin
      peak_cnt_reg <= 8'h00;
      vmax_reg     <= 24'h000000;
      vmax_ph_reg  <= 3'h0;
      imax_reg     <= 24'h000000;
      imax_ph_reg  <= 3'h0;
    end else if (window_end) begin
      peak_cnt_reg <= 8'h00;
      // latch value and one-hot phase, hold for next window
      voltage_peak_value <= {vcand_ph, vcand};
      current_peak_value <= {icand_ph, icand};
      vmax_reg     <= 24'h000000;
      vmax_ph_reg  <= 3'h0;
      imax_reg     <= 24'h000000;
      imax_ph_reg  <= 3'h0;
    end else begin
      if (zx_sel) begin
        peak_cnt_reg <= peak_cnt_inc;
      end
      vmax_reg    <= vcand;
      vmax_ph_reg <= vcand_ph;
      imax_reg    <= icand;
      imax_ph_reg <= icand_ph;
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and interrupt
  // ----------------------------------------------------------------
  // only bits written as one clear; a same-cycle set wins
  // writing bit 16 as one clears the dip flag
  wire dip_flag_next = (dip_flag_reg & ~(wr_status & REG_WDATA[`BIT_DIP_EVENT])) | (|dip_fire);
  wire ipk_next = (current_peak_done_flag & ~(wr_status & REG_WDATA[`BIT_CURR_PEAK_DONE])) | window_end;
  wire vpk_next = (voltage_peak_done_flag & ~(wr_status & REG_WDATA[`BIT_VOLT_PEAK_DONE])) | window_end;

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dip_flag_reg           <= 1'b0;
      current_peak_done_flag <= 1'b0;
      voltage_peak_done_flag <= 1'b0;
      IRQ_N                  <= 1'b1;
    end else begin
      // dip flag on any phase result
      dip_flag_reg           <= dip_flag_next;
      current_peak_done_flag <= ipk_next;
      voltage_peak_done_flag <= vpk_next;
      // interrupt falls with the flag, from the same next value
      IRQ_N <= ~|({vpk_next, ipk_next, dip_flag_next} & event_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dip_threshold_reg          <= `RST_DIP_THRESHOLD;
      dip_threshold_set_reg      <= 1'b0;
      dip_half_cycle_count_reg   <= `RST_DIP_COUNT;
      peak_phase_select_reg      <= `RST_PEAK_SEL;
      peak_window_halfcycles_reg <= `RST_PEAK_WINDOW;
      event_mask_reg             <= `RST_MASK;
      REG_RDATA                  <= 32'h00000000;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          `ADDR_EVENT_MASK: begin
            event_mask_reg <= {REG_WDATA[`BIT_VOLT_PEAK_DONE], REG_WDATA[`BIT_CURR_PEAK_DONE],
                               REG_WDATA[`BIT_DIP_EVENT]};
          end
          `ADDR_DIP_THRESHOLD: begin
            dip_threshold_reg     <= REG_WDATA[23:0];
            dip_threshold_set_reg <= 1'b1;
          end
          `ADDR_DIP_COUNT: begin
            dip_half_cycle_count_reg <= REG_WDATA[7:0];
          end
          `ADDR_MEAS_MODE: begin
            peak_phase_select_reg <= REG_WDATA[`POS_PEAK_SEL_LO+2:`POS_PEAK_SEL_LO];
          end
          `ADDR_PEAK_WINDOW: begin
            peak_window_halfcycles_reg <= REG_WDATA[7:0];
          end
          default: begin
          end
        endcase
      end
      if (REG_RD) begin
        REG_RDATA <= 32'h00000000;
        case (REG_ADDR)
          `ADDR_EVENT_STATUS: begin
            REG_RDATA[`BIT_DIP_EVENT]      <= dip_flag_reg;
            REG_RDATA[`BIT_CURR_PEAK_DONE] <= current_peak_done_flag;
            REG_RDATA[`BIT_VOLT_PEAK_DONE] <= voltage_peak_done_flag;
          end
          `ADDR_EVENT_MASK: begin
            REG_RDATA[`BIT_DIP_EVENT]      <= event_mask_reg[0];
            REG_RDATA[`BIT_CURR_PEAK_DONE] <= event_mask_reg[1];
            REG_RDATA[`BIT_VOLT_PEAK_DONE] <= event_mask_reg[2];
          end
          `ADDR_PHASE_STATUS: begin
            REG_RDATA[`POS_DIP_PHASE_LO+2:`POS_DIP_PHASE_LO] <= dip_phase_state;
          end
          // threshold padded to 32 bits with zeros
          `ADDR_DIP_THRESHOLD: begin
            REG_RDATA <= {8'h00, dip_threshold_reg};
          end
          `ADDR_DIP_COUNT: begin
            REG_RDATA <= {24'h000000, dip_half_cycle_count_reg};
          end
          `ADDR_MEAS_MODE: begin
            REG_RDATA[`POS_PEAK_SEL_LO+2:`POS_PEAK_SEL_LO] <= peak_phase_select_reg;
          end
          `ADDR_PEAK_WINDOW: begin
            REG_RDATA <= {24'h000000, peak_window_halfcycles_reg};
          end
          `ADDR_VOLT_PEAK: begin
            REG_RDATA <= {5'h00, voltage_peak_value};
          end
          `ADDR_CURR_PEAK: begin
            REG_RDATA <= {5'h00, current_peak_value};
          end
          default: begin
            REG_RDATA <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // voltage_dip_and_peak_monitor

// ---- test/dip_peak_monitor_monitor.sv ----
// assertion checker on the ports of the dip and peak monitor
`timescale 1ns/1ps
module dip_peak_monitor (
  // clock and reset
  input wire        SYS_CLK,
  input wire        RST_N,
  // register port
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [3:0]  REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire [31:0] REG_RDATA,
  // zero crossings and interrupt
  input wire        ZX_A,
  input wire        ZX_B,
  input wire        ZX_C,
  input wire        IRQ_N
);
  reg  [23:0] thr_reg;
  reg  [7:0]  cnt_reg;
  wire        rd_only = REG_RD && !REG_WR;
  wire        wr_st   = REG_WR && REG_ADDR < 4'h2;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------
  // write shadows of the dip settings
  // ----------------------------------------
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      thr_reg <= 24'h000000;
      cnt_reg <= 8'h00;
    end else if (REG_WR && REG_ADDR == 4'h3)
      thr_reg <= REG_WDATA[23:0];
    else if (REG_WR && REG_ADDR == 4'h4)
      cnt_reg <= REG_WDATA[7:0];
  end
  a_thr_readback: assert property (rd_only && REG_ADDR == 4'h3 |=> REG_RDATA == {8'h00, thr_reg})
    else $error("threshold readback wrong");
  a_cnt_readback: assert property (rd_only && REG_ADDR == 4'h4 |=> REG_RDATA == {24'h000000, cnt_reg})
    else $error("dip count readback wrong");
  a_peak_format: assert property (REG_RD && REG_ADDR inside {4'h7, 4'h8} |=>
    REG_RDATA[31:27] == 5'h00 && $onehot0(REG_RDATA[26:24]))
    else $error("peak word format wrong");
  a_phase_bits_only: assert property (REG_RD && REG_ADDR == 4'h2 |=> (REG_RDATA & 32'hffff8fff) == 32'h0)
    else $error("phase status stray bits");
  a_status_bits_only: assert property (REG_RD && REG_ADDR == 4'h0 |=> (REG_RDATA & 32'hfe7effff) == 32'h0)
    else $error("event status stray bits");
  a_irq_fall_cause: assert property ($fell(IRQ_N) |->
    $past(ZX_A || ZX_B || ZX_C) || $past(REG_WR && REG_ADDR == 4'h1, 2))
    else $error("interrupt fell without cause");
  a_irq_rise_cause: assert property ($rose(IRQ_N) |-> $past(wr_st) || $past(wr_st, 2) || !$past(RST_N))
    else $error("interrupt released without write");
  a_irq_held_low: assert property (!IRQ_N && !wr_st && !$past(REG_WR && REG_ADDR == 4'h1) |=> !IRQ_N)
    else $error("interrupt released early");
endmodule // dip_peak_monitor

bind voltage_dip_and_peak_monitor dip_peak_monitor u_mon (.SYS_CLK, .RST_N, .REG_WR, .REG_RD, .REG_ADDR,
  .REG_WDATA, .REG_RDATA, .ZX_A, .ZX_B, .ZX_C, .IRQ_N);

// ---- test/host_model.sv ----
// host side of the register port
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire        clk,
  // register port
  output reg         wr,
  output reg         rd,
  output reg  [3:0]  addr,
  output reg  [31:0] wdata,
  input  wire [31:0] rdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
  end
  // released lines take the inverse so stale values cannot pass
  task put(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk) #1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk) #1;
      wr = 1'b0;
      addr = ~a;
      wdata = ~d;
    end
  endtask
  task get(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk) #1;
      rd = 1'b1;
      addr = a;
      @(posedge clk) #1;
      rd = 1'b0;
      addr = ~a;
      d = rdata;
    end
  endtask
endmodule // host_model

// ---- test/voltage_dip_and_peak_monitor_tb_top.sv ----
// self-checking bench for the dip and peak monitor
`timescale 1ns/1ps
module voltage_dip_and_peak_monitor_tb_top;
  reg         sys_clk, rst_n, zx_a, zx_b, zx_c, sample_valid;
  reg  [23:0] v_a, v_b, v_c, i_a, i_b, i_c;
  wire        reg_wr, reg_rd, irq_n;
  wire [3:0]  reg_addr;
  wire [31:0] reg_wdata, reg_rdata;
  reg  [31:0] got;
  reg  [67:0] rows [0:8];
  integer     err_count, compares, k;

  voltage_dip_and_peak_monitor dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SAMPLE_VALID(sample_valid),
    .V_A(v_a), .V_B(v_b), .V_C(v_c), .I_A(i_a), .I_B(i_b), .I_C(i_c),
    .ZX_A(zx_a), .ZX_B(zx_b), .ZX_C(zx_c), .IRQ_N(irq_n));
  host_model host (.clk(sys_clk), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr), .wdata(reg_wdata),
    .rdata(reg_rdata));

  always #2.5 sys_clk = ~sys_clk;

  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rchk(input [3:0] a, input [31:0] e);
    begin
      host.get(a, got);
      chk("register", e, got);
    end
  endtask
  task zx(input [2:0] m);
    begin
      @(posedge sys_clk) #1;
      {zx_c, zx_b, zx_a} = m;
      @(posedge sys_clk) #1;
      {zx_c, zx_b, zx_a} = 3'b000;
      repeat (3) @(posedge sys_clk);
      #1;
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #100000;
    err_count = err_count + 1;
    summarize;
  end

  initial begin
    {sys_clk, rst_n, zx_a, zx_b, zx_c} = 5'h00;
    sample_valid = 1'b1;
    {v_a, v_b, v_c} = {24'hff0000, 24'h000010, 24'h000010};
    {i_a, i_b, i_c} = {24'h000200, 24'h7fffff, 24'h000001};
    err_count = 0;
    compares = 0;
    rows[0] = {4'h3, 32'hffffffff, 32'h00ffffff};
    rows[1] = {4'h3, 32'h005a7540, 32'h005a7540};
    rows[2] = {4'h4, 32'h00000107, 32'h00000007};
    rows[3] = {4'h5, 32'hffffffff, 32'h0000001c};
    rows[4] = {4'h6, 32'h000001ab, 32'h000000ab};
    rows[5] = {4'h1, 32'hffffffff, 32'h01810000};
    rows[6] = {4'h2, 32'hffffffff, 32'h00000000};
    rows[7] = {4'h7, 32'hffffffff, 32'h00000000};
    rows[8] = {4'h9, 32'hffffffff, 32'h00000000};
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    for (k = 0; k < 9; k = k + 1)
      rchk(k[3:0], 32'h0);
    chk("irq", 32'h1, {31'h0, irq_n});
    $display("test reset done");
    for (k = 0; k < 9; k = k + 1) begin
      host.put(rows[k][67:64], rows[k][63:32]);
      rchk(rows[k][67:64], rows[k][31:0]);
    end
    $display("test registers done");
    // ----------------------------------------
    // dip below then above on phase A, then below on phases B and C
    // ----------------------------------------
    host.put(4'h4, 32'h2);
    zx(3'b001);
    rchk(4'h0, 32'h0);
    zx(3'b001);
    chk("irq", 32'h0, {31'h0, irq_n});
    rchk(4'h0, 32'h00010000);
    rchk(4'h2, 32'h00001000);
    host.put(4'h0, 32'h01800000);
    rchk(4'h0, 32'h00010000);
    host.put(4'h0, 32'h00010000);
    chk("irq", 32'h1, {31'h0, irq_n});
    v_a = 24'h600000;
    zx(3'b001);
    host.put(4'h4, 32'h2);
    zx(3'b001);
    chk("irq", 32'h1, {31'h0, irq_n});
    zx(3'b001);
    rchk(4'h2, 32'h0);
    host.put(4'h0, 32'h00010000);
    host.put(4'h4, 32'h2);
    zx(3'b110);
    zx(3'b110);
    rchk(4'h2, 32'h00006000);
    host.put(4'h4, 32'h0);
    host.put(4'h0, 32'h00010000);
    $display("test dip done");
    // ----------------------------------------
    // peak windows, phase A then A and B
    // ----------------------------------------
    v_a = 24'hf00000;
    v_b = 24'h7fffff;
    host.put(4'h5, 32'h04);
    host.put(4'h6, 32'h02);
    zx(3'b001);
    rchk(4'h0, 32'h0);
    zx(3'b001);
    chk("irq", 32'h0, {31'h0, irq_n});
    rchk(4'h0, 32'h01800000);
    rchk(4'h7, 32'h01100000);
    rchk(4'h8, 32'h01000200);
    v_a = 24'h200000;
    zx(3'b001);
    rchk(4'h7, 32'h01100000);
    host.put(4'h0, 32'h01800000);
    host.put(4'h5, 32'h0c);
    host.put(4'h6, 32'h02);
    zx(3'b010);
    zx(3'b001);
    rchk(4'h7, 32'h027fffff);
    rchk(4'h8, 32'h027fffff);
    host.put(4'h0, 32'h01800000);
    chk("irq", 32'h1, {31'h0, irq_n});
    // samples without the valid strobe must not reach the peak
    host.put(4'h6, 32'h02);
    sample_valid = 1'b0;
    zx(3'b001);
    zx(3'b001);
    rchk(4'h7, 32'h00000000);
    sample_valid = 1'b1;
    host.put(4'h0, 32'h01800000);
    chk("irq", 32'h1, {31'h0, irq_n});
    $display("test peak done");
    summarize;
  end
endmodule // voltage_dip_and_peak_monitor_tb_top
